// ---- hdl/in_slot_tracker.sv ----
// Counts packets committed to the IN FIFO and holds one back until a frame.
// Assumes the owner never commits beyond the slot capacity.
`timescale 1ns/100ps
module in_slot_tracker
    import usb_in_ep_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    in_slot_if.tracker slots
);

    logic [1:0] count_reg;
    logic       held_reg;

    // Commit and release in one cycle leave the count unchanged
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_reg <= SLOTS_EMPTY;
        end else if (slots.commit && !slots.release_pkt) begin
            count_reg <= count_reg + 2'h1;
        end else if (!slots.commit && slots.release_pkt && count_reg != SLOTS_EMPTY) begin
            count_reg <= count_reg - 2'h1;
        end
    end

    // Held packet becomes sendable at the next frame start
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            held_reg <= 1'b0;
        end else if (slots.commit && slots.hold_req) begin
            held_reg <= 1'b1; // see [R04]
        end else if (slots.sof) begin
            held_reg <= 1'b0;
        end
    end

    assign slots.count    = count_reg;
    assign slots.held     = held_reg;
    // Only the newest packet is ever held, so older ones stay sendable
    assign slots.eligible = (count_reg > {1'b0, held_reg});

endmodule

// ---- hdl/usb_in_endpoint_ctrl_low.sv ----
// Low control byte of one indexed IN endpoint and its packet handshake.
// Assumes the serial engine and high control byte share the core clock.
// Summary of operation
// [R01] Firmware loads whole packet before setting ready
// [R02] Transmitted packet clears packet ready bit
// [R03] Open double-buffer slot clears packet ready
// [R04] Iso update hides ready until next frame
// [R05] Interrupt only for transmitted packet clears
// [R06] Stall request answers every token with STALL (code: non-iso tokens only)
// [R07] STALL sets sticky flag, interrupts; firmware clears
// [R08] Iso token without packet: empty packet, underrun
// [R09] Flush with data drops packet, interrupts, self-clears
// [R10] Clear-toggle write zeroes toggle, reads zero
`timescale 1ns/100ps
module usb_in_endpoint_ctrl_low
    import usb_in_ep_pkg::*;
#(
    parameter logic [1:0] ENDPOINT_NUM = 2'h1
)
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    // Indexed register port
    input  wire logic [1:0] reg_index_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // Settings from the high control byte
    input  wire logic       double_buffer_enable_i,
    input  wire logic       iso_mode_i,
    input  wire logic       iso_update_option_i,
    input  wire logic       force_toggle_i,
    // Serial engine events
    input  wire logic       in_token_i,
    input  wire logic       tx_done_i,
    input  wire logic       sof_i,
    // Serial engine commands
    output logic            send_data_o,
    output logic            send_stall_o,
    output logic            send_zero_len_o,
    output logic            fifo_flush_o,
    output logic            data_toggle_o,
    output logic            ep_irq_o
);

    in_slot_if slots ();

    logic         packet_ready_reg;
    logic         underrun_reg;
    logic         send_stall_req_reg;
    logic         stall_sent_reg;
    logic         flush_bit_reg;
    flush_state_t flush_state_reg;
    logic         toggle_reg;
    logic [7:0]   rdata_reg;
    logic         send_data_reg;
    logic         send_stall_reg;
    logic         send_zlp_reg;
    logic         flush_pulse_reg;
    logic         irq_reg;

    logic         sel;
    logic         wr_hit;
    logic         rd_hit;
    logic [1:0]   capacity;
    logic         commit;
    logic         stall_fire;
    logic         data_fire;
    logic         zlp_fire;
    logic         flush_fire;
    logic         toggle_event;
    logic [7:0]   read_value;

    // Packed byte as firmware sees it
    function automatic logic [7:0] pack_byte(input logic ready, input logic not_empty,
                                             input logic under, input logic flush,
                                             input logic stall_req, input logic stall_sent);
        logic [7:0] b;
        b = 8'h00;
        b[BIT_PACKET_READY]   = ready;
        b[BIT_FIFO_NOT_EMPTY] = not_empty;
        b[BIT_UNDERRUN]       = under;
        b[BIT_FLUSH]          = flush;
        b[BIT_SEND_STALL]     = stall_req;
        b[BIT_STALL_SENT]     = stall_sent;
        return b;
    endfunction

    in_slot_tracker u_slots (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .slots      (slots.tracker)
    );

    // Register decode for this endpoint's index
    assign sel      = (reg_index_i == ENDPOINT_NUM) && (reg_addr_i == IN_CTRL_LOW_OFFSET);
    assign wr_hit   = sel && reg_wr_i;
    assign rd_hit   = sel && reg_rd_i;
    assign capacity = double_buffer_enable_i ? SLOTS_DOUBLE : SLOTS_SINGLE;

    // Data must already be in the FIFO; a full FIFO ignores the commit
    assign commit = wr_hit && reg_wdata_i[BIT_PACKET_READY] && (slots.count < capacity); // see [R01]

    // Token answers; stall has no meaning in iso mode
    assign stall_fire = in_token_i && send_stall_req_reg && !iso_mode_i;                 // see [R06]
    assign data_fire  = in_token_i && !stall_fire && slots.eligible;
    assign zlp_fire   = in_token_i && iso_mode_i && !slots.eligible;                     // see [R08]
    assign flush_fire = (flush_state_reg == FLUSH_DROP);

    // Forced toggle flips on every data send, otherwise only on a completed transfer
    assign toggle_event = force_toggle_i ? data_fire : tx_done_i;

    assign slots.commit      = commit;
    assign slots.release_pkt = tx_done_i || flush_fire;
    assign slots.sof         = sof_i;
    assign slots.hold_req    = iso_mode_i && iso_update_option_i;

    // Held packet reads as not ready
    assign read_value = pack_byte(packet_ready_reg && !slots.held,                        // see [R04]
                                  slots.count != SLOTS_EMPTY, underrun_reg, flush_bit_reg,
                                  send_stall_req_reg, stall_sent_reg);

    // Packet ready: set by firmware, cleared once a slot is open
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            packet_ready_reg <= 1'b0;
        end else if (commit) begin
            packet_ready_reg <= 1'b1;
        end else if (packet_ready_reg && slots.count < capacity) begin
            packet_ready_reg <= 1'b0; // see [R02] see [R03]
        end
    end

    // Underrun is sticky; the set wins over a firmware clear
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            underrun_reg <= 1'b0;
        end else if (zlp_fire) begin
            underrun_reg <= 1'b1; // see [R08]
        end else if (wr_hit && !reg_wdata_i[BIT_UNDERRUN]) begin
            underrun_reg <= 1'b0;
        end
    end

    // Stall request is a plain firmware bit
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            send_stall_req_reg <= 1'b0;
        end else if (wr_hit) begin
            send_stall_req_reg <= reg_wdata_i[BIT_SEND_STALL];
        end
    end

    // Stall sent: only firmware writing zero clears it
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stall_sent_reg <= 1'b0;
        end else if (stall_fire) begin
            stall_sent_reg <= 1'b1; // see [R07]
        end else if (wr_hit && !reg_wdata_i[BIT_STALL_SENT]) begin
            stall_sent_reg <= 1'b0;
        end
    end

    // Flush: an empty FIFO ignores the request, so no interrupt either
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flush_state_reg <= FLUSH_IDLE;
            flush_bit_reg   <= 1'b0;
        end else begin
            case (flush_state_reg)
                FLUSH_IDLE: begin
                    if (wr_hit && reg_wdata_i[BIT_FLUSH] && slots.count != SLOTS_EMPTY) begin
                        flush_state_reg <= FLUSH_DROP; // see [R09]
                        flush_bit_reg   <= 1'b1;
                    end
                end
                FLUSH_DROP: begin
                    flush_state_reg <= FLUSH_IDLE;
                    flush_bit_reg   <= 1'b0; // see [R09]
                end
                default: begin
                    flush_state_reg <= FLUSH_IDLE;
                    flush_bit_reg   <= 1'b0;
                end
            endcase
        end
    end

    // Data toggle; a clear-toggle write beats a same-cycle toggle
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            toggle_reg <= 1'b0;
        end else if (wr_hit && reg_wdata_i[BIT_CLEAR_TOGGLE]) begin
            toggle_reg <= 1'b0; // see [R10]
        end else if (toggle_event) begin
            toggle_reg <= !toggle_reg;
        end
    end

    // Read data registered; clear-toggle position always reads zero
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= IN_CTRL_LOW_RESET;
        end else if (rd_hit) begin
            rdata_reg <= read_value; // see [R10]
        end
    end

    // One-cycle commands to the serial engine
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            send_data_reg   <= 1'b0;
            send_stall_reg  <= 1'b0;
            send_zlp_reg    <= 1'b0;
            flush_pulse_reg <= 1'b0;
        end else begin
            send_data_reg   <= data_fire;
            send_stall_reg  <= stall_fire; // see [R06]
            send_zlp_reg    <= zlp_fire;   // see [R08]
            flush_pulse_reg <= flush_fire; // see [R09]
        end
    end

    // Interrupt pulse; slot-open clears never raise it
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= tx_done_i || stall_fire || flush_fire; // see [R05] see [R07] see [R09]
        end
    end

    assign reg_rdata_o     = rdata_reg;
    assign send_data_o     = send_data_reg;
    assign send_stall_o    = send_stall_reg;
    assign send_zero_len_o = send_zlp_reg;
    assign fifo_flush_o    = flush_pulse_reg;
    assign data_toggle_o   = toggle_reg;
    assign ep_irq_o        = irq_reg;

endmodule

// ---- shared/in_slot_if.sv ----
// Carrier between the endpoint control byte and its packet slot tracker.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface in_slot_if;
    logic       commit;      // Firmware hands over one packet
    logic       release_pkt; // One packet leaves (sent or flushed)
    logic       sof;         // Start of frame seen
    logic       hold_req;    // New packet waits for the next frame
    logic [1:0] count;       // Packets held in the FIFO
    logic       held;        // Newest packet still waiting for a frame
    logic       eligible;    // A packet may go out now

    modport owner   (output commit, output release_pkt, output sof, output hold_req,
                     input count, input held, input eligible);
    modport tracker (input commit, input release_pkt, input sof, input hold_req,
                     output count, output held, output eligible);
endinterface

// ---- shared/usb_in_ep_pkg.sv ----
// Constants for the low control byte of one indexed IN endpoint.
// Assumes a byte-wide indexed register space on the core clock.
package usb_in_ep_pkg;

    // Register placement and reset value
    localparam logic [7:0] IN_CTRL_LOW_OFFSET = 8'h11;
    localparam logic [7:0] IN_CTRL_LOW_RESET  = 8'h00;

    // Field positions within the low control byte
    localparam int BIT_PACKET_READY   = 0;
    localparam int BIT_FIFO_NOT_EMPTY = 1;
    localparam int BIT_UNDERRUN       = 2;
    localparam int BIT_FLUSH          = 3;
    localparam int BIT_SEND_STALL     = 4;
    localparam int BIT_STALL_SENT     = 5;
    localparam int BIT_CLEAR_TOGGLE   = 6;

    // Packet slot capacity of the endpoint FIFO
    localparam logic [1:0] SLOTS_SINGLE = 2'h1;
    localparam logic [1:0] SLOTS_DOUBLE = 2'h2;
    localparam logic [1:0] SLOTS_EMPTY  = 2'h0;

    // Flush sequencing
    typedef enum logic [0:0] {
        FLUSH_IDLE,
        FLUSH_DROP
    } flush_state_t;

endpackage

// ---- test/test_usb_in_endpoint_ctrl_low.sv ----
// Self-checking bench for the IN endpoint control byte.
// Assumes the host model answers each data send with an ACK.
`timescale 1ns/100ps
module test_usb_in_endpoint_ctrl_low;
    import usb_in_ep_pkg::*;
    logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [1:0]  reg_index_i = 2'h1;
    logic [7:0]  reg_addr_i = 8'h11, reg_wdata_i = 8'h00, reg_rdata_o;
    logic        double_buffer_enable_i = 1'b0, iso_mode_i = 1'b0, iso_update_option_i = 1'b0;
    logic        force_toggle_i = 1'b0, tok_req = 1'b0, sof_req = 1'b0, toggle_exp = 1'b0;
    logic        in_token_i, tx_done_i, sof_i, send_data_o, send_stall_o, send_zero_len_o;
    logic        fifo_flush_o, data_toggle_o, ep_irq_o;
    logic [3:0]  ack_delay = 4'h0;
    logic [7:0]  n_data = 8'h00, n_stall = 8'h00, n_zero = 8'h00, n_flush = 8'h00, n_irq = 8'h00;
    logic [31:0] rng = 32'hD8EF;
    int          fails = 0, samples_checked = 0;
    usb_in_endpoint_ctrl_low #(.ENDPOINT_NUM(2'h1)) dut (
        .core_clk_i             (core_clk_i),
        .sys_rst_i              (sys_rst_i),
        .reg_index_i            (reg_index_i),
        .reg_addr_i             (reg_addr_i),
        .reg_wr_i               (reg_wr_i),
        .reg_rd_i               (reg_rd_i),
        .reg_wdata_i            (reg_wdata_i),
        .reg_rdata_o            (reg_rdata_o),
        .double_buffer_enable_i (double_buffer_enable_i),
        .iso_mode_i             (iso_mode_i),
        .iso_update_option_i    (iso_update_option_i),
        .force_toggle_i         (force_toggle_i),
        .in_token_i             (in_token_i),
        .tx_done_i              (tx_done_i),
        .sof_i                  (sof_i),
        .send_data_o            (send_data_o),
        .send_stall_o           (send_stall_o),
        .send_zero_len_o        (send_zero_len_o),
        .fifo_flush_o           (fifo_flush_o),
        .data_toggle_o          (data_toggle_o),
        .ep_irq_o               (ep_irq_o)
    );
    usb_host_model host (.clk_i(core_clk_i), .rst_i(sys_rst_i), .tok_req_i(tok_req), .sof_req_i(sof_req),
        .ack_delay_i(ack_delay), .send_data_i(send_data_o), .in_token_o(in_token_i), .sof_o(sof_i),
        .tx_done_o(tx_done_i));
    // Clock and engine pulse tallies (one-cycle pulses are easy to miss)
    always #5 core_clk_i = ~core_clk_i;
    // Skipped in reset: outputs are unknown until the first reset edge lands
    always @(posedge core_clk_i) begin
        if (!sys_rst_i) begin
            n_data  += {7'h00, send_data_o};
            n_stall += {7'h00, send_stall_o};
            n_zero  += {7'h00, send_zero_len_o};
            n_flush += {7'h00, fifo_flush_o};
            n_irq   += {7'h00, ep_irq_o};
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b1;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    // Extra edges first so automatic clears have landed
    task automatic rd(input string what, input logic [7:0] exp);
        repeat (2) @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
        #1 check(what, reg_rdata_o, exp);
    endtask
    task automatic host_req(input logic frame);
        @(posedge core_clk_i);
        tok_req <= !frame;
        sof_req <= frame;
        @(posedge core_clk_i);
        tok_req <= 1'b0;
        sof_req <= 1'b0;
        repeat (24) @(posedge core_clk_i);
    endtask
    // Stray write to a wrong address or index; also picks ACK latency
    task automatic miss();
        rng = xs(rng);
        @(posedge core_clk_i);
        reg_addr_i  <= rng[7:0] == 8'h11 ? 8'h12 : rng[7:0];
        reg_index_i <= rng[8] ? 2'h1 : 2'h3;
        reg_wdata_i <= rng[15:8];
        reg_wr_i    <= 1'b1;
        ack_delay   <= rng[19:16];
        @(posedge core_clk_i);
        reg_wr_i    <= 1'b0;
        reg_addr_i  <= 8'h11;
        reg_index_i <= 2'h1;
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog: the sequence needs about 400 cycles
    initial begin
        #50us;
        fails++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd("reset value", IN_CTRL_LOW_RESET);
        for (int i = 0; i < 3; i++) begin
            miss();
            wr(8'h01);
            rd("ready set", 8'h03);
            host_req(1'b0);
            toggle_exp = ~toggle_exp;
            rd("ready cleared", 8'h00);
            check("toggle", {7'h00, data_toggle_o}, {7'h00, toggle_exp});
        end
        check("bulk irqs", n_irq, 8'h03);
        $display("test bulk done");
        double_buffer_enable_i <= 1'b1;
        wr(8'h01);
        rd("slot open", 8'h02);
        wr(8'h01);
        rd("both slots", 8'h03);
        check("no slot irq", n_irq, 8'h03);
        host_req(1'b0);
        host_req(1'b0);
        rd("drained", 8'h00);
        check("send irqs", n_irq, 8'h05);
        wr(8'h40);
        rd("clear reads 0", 8'h00);
        check("toggle cleared", {7'h00, data_toggle_o}, 8'h00);
        $display("test double buffer done");
        double_buffer_enable_i <= 1'b0;
        wr(8'h01);
        wr(8'h08);
        rd("flushed", 8'h00);
        wr(8'h08);
        rd("empty flush", 8'h00);
        check("flush pulses", n_flush, 8'h01);
        check("flush irq", n_irq, 8'h06);
        wr(8'h10);
        host_req(1'b0);
        rd("stall sent", 8'h30);
        check("stall pulse", n_stall, 8'h01);
        check("no data", n_data, 8'h05);
        check("stall irq", n_irq, 8'h07);
        wr(8'h10);
        rd("stall flag cleared", 8'h10);
        wr(8'h00);
        $display("test flush and stall done");
        iso_mode_i <= 1'b1;
        host_req(1'b0);
        check("zero length", n_zero, 8'h01);
        rd("underrun", 8'h04);
        wr(8'h00);
        iso_update_option_i <= 1'b1;
        wr(8'h01);
        rd("held for frame", 8'h02);
        host_req(1'b1);
        rd("ready after frame", 8'h03);
        host_req(1'b0);
        rd("iso sent", 8'h00);
        check("iso irq", n_irq, 8'h08);
        $display("test iso done");
        // Forced toggle flips at the send, long before a slow ACK
        iso_mode_i          <= 1'b0;
        iso_update_option_i <= 1'b0;
        force_toggle_i      <= 1'b1;
        ack_delay           <= 4'hF;
        wr(8'h41);
        rd("forced ready", 8'h03);
        check("toggle zeroed", {7'h00, data_toggle_o}, 8'h00);
        @(posedge core_clk_i);
        tok_req <= 1'b1;
        @(posedge core_clk_i);
        tok_req <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        #1 check("forced early", {7'h00, data_toggle_o}, 8'h01);
        repeat (24) @(posedge core_clk_i);
        check("forced once", {7'h00, data_toggle_o}, 8'h01);
        rd("forced sent", 8'h00);
        check("forced irq", n_irq, 8'h09);
        check("forced data", n_data, 8'h07);
        $display("test forced toggle done");
        summarize();
    end
endmodule

// ---- test/usb_host_model.sv ----
// Host side: issues IN tokens and frames, ACKs each data packet.
// Assumes the bench requests tokens and sets the ACK latency.
`timescale 1ns/100ps
module usb_host_model
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tok_req_i,
    input  wire logic       sof_req_i,
    input  wire logic [3:0] ack_delay_i,
    input  wire logic       send_data_i,
    output logic            in_token_o,
    output logic            sof_o,
    output logic            tx_done_o
);
    logic [4:0] wait_cnt;
    // Token and frame pulses, one cycle each
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_token_o <= 1'b0;
            sof_o      <= 1'b0;
        end else begin
            in_token_o <= tok_req_i;
            sof_o      <= sof_req_i;
        end
    end
    // ACK only after data really went out; latency varies
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_cnt  <= 5'h00;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= wait_cnt == 5'h01;
            if (send_data_i) begin
                wait_cnt <= {1'b0, ack_delay_i} + 5'h01;
            end else if (wait_cnt != 5'h00) begin
                wait_cnt <= wait_cnt - 5'h01;
            end
        end
    end
endmodule

// ---- test/usb_in_ep_props.sv ----
// Port-level checks for the IN endpoint control byte.
// Bound into the top module; sees its ports only.
`timescale 1ns/100ps
module usb_in_ep_props
    import usb_in_ep_pkg::*;
#(parameter logic [1:0] ENDPOINT_NUM = 2'h1)
(
    input wire logic       core_clk_i,
    input wire logic       sys_rst_i,
    input wire logic [1:0] reg_index_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       iso_mode_i,
    input wire logic       in_token_i,
    input wire logic       tx_done_i,
    input wire logic       send_data_o,
    input wire logic       send_stall_o,
    input wire logic       send_zero_len_o,
    input wire logic       fifo_flush_o,
    input wire logic       data_toggle_o,
    input wire logic       ep_irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Write decode; flush and clear are one-shot commands
    logic wr_hit;
    logic flush_wr;
    assign wr_hit   = reg_wr_i && reg_index_i == ENDPOINT_NUM && reg_addr_i == IN_CTRL_LOW_OFFSET;
    assign flush_wr = wr_hit && reg_wdata_i[BIT_FLUSH];
    sequence s_clear_wr;
        wr_hit && reg_wdata_i[BIT_CLEAR_TOGGLE];
    endsequence
    sequence s_answer;
        send_data_o || send_stall_o || send_zero_len_o;
    endsequence
    chk_toggle_clear: assert property (s_clear_wr |=> !data_toggle_o)
        else $error("toggle not cleared");
    chk_high_bits: assert property (reg_rdata_o[7:6] == 2'h0)
        else $error("bits 7:6 read nonzero");
    chk_token_cause: assert property (s_answer |-> $past(in_token_i))
        else $error("answer without token");
    chk_stall_only: assert property (send_stall_o |-> ep_irq_o && !send_data_o && !$past(iso_mode_i))
        else $error("bad stall answer");
    chk_zero_iso: assert property (send_zero_len_o |-> $past(iso_mode_i) && !ep_irq_o)
        else $error("bad zero-length answer");
    chk_sent_irq: assert property (tx_done_i |=> ep_irq_o)
        else $error("no irq after send");
    chk_irq_cause: assert property (ep_irq_o |-> $past(tx_done_i) || send_stall_o || fifo_flush_o)
        else $error("irq without cause");
    chk_flush_step: assert property (fifo_flush_o |-> ep_irq_o && $past(flush_wr, 2))
        else $error("flush pulse off");
endmodule
bind usb_in_endpoint_ctrl_low usb_in_ep_props #(.ENDPOINT_NUM(ENDPOINT_NUM)) chk (
    .core_clk_i      (core_clk_i),
    .sys_rst_i       (sys_rst_i),
    .reg_index_i     (reg_index_i),
    .reg_addr_i      (reg_addr_i),
    .reg_wr_i        (reg_wr_i),
    .reg_wdata_i     (reg_wdata_i),
    .reg_rdata_o     (reg_rdata_o),
    .iso_mode_i      (iso_mode_i),
    .in_token_i      (in_token_i),
    .tx_done_i       (tx_done_i),
    .send_data_o     (send_data_o),
    .send_stall_o    (send_stall_o),
    .send_zero_len_o (send_zero_len_o),
    .fifo_flush_o    (fifo_flush_o),
    .data_toggle_o   (data_toggle_o),
    .ep_irq_o        (ep_irq_o)
);
